// file: hdl/sbd_pkg.sv
// shared constants and carrier types for the buffer drop status bank
package sbd_pkg;
  // register numbers on the system register path
  localparam logic [15:0] ADDR_TAG2  = 16'h1c15;
  localparam logic [15:0] ADDR_CNT0  = 16'h1c16;
  localparam logic [15:0] ADDR_CNT1  = 16'h1c17;
  localparam logic [15:0] ADDR_CNT2  = 16'h1c18;
  localparam logic [15:0] ADDR_MASK  = 16'h1c20;
  localparam logic [15:0] ADDR_PEND  = 16'h1c21;
  // default tag fields
  localparam int          PRIO_LSB   = 12;
  localparam int          VID_LSB    = 0;
  localparam logic [2:0]  PRIO_RST   = 3'h0;
  localparam logic [11:0] VID_RST    = 12'h001;
  // counters
  localparam logic [31:0] CNT_RST    = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX    = 32'h0fff_ffff;
  // mask
  localparam int          MASK_BIT   = 0;
  localparam logic        MASK_RST   = 1'b1;
  // pending register field positions
  localparam int          REASON_B_LSB = 10;
  localparam int          PORT_B_LSB   = 8;
  localparam int          PEND_B_BIT   = 7;
  localparam int          REASON_A_LSB = 3;
  localparam int          PORT_A_LSB   = 1;
  localparam int          VALID_A_BIT  = 0;
  // drop reason codes
  localparam logic [3:0] RSN_BCAST_LVL = 4'h0;
  localparam logic [3:0] RSN_RED       = 4'h1;
  localparam logic [3:0] RSN_NO_BUF    = 4'h2;
  localparam logic [3:0] RSN_NO_DESC   = 4'h3;
  localparam logic [3:0] RSN_NO_DEST   = 4'h4;
  localparam logic [3:0] RSN_RX_ERR    = 4'h5;
  localparam logic [3:0] RSN_DROP_LVL  = 4'h6;
  localparam logic [3:0] RSN_YELLOW    = 4'h9;
  // source port codes
  localparam logic [1:0] SRC_PORT0     = 2'h0;
  localparam logic [1:0] SRC_PORT1     = 2'h1;
  localparam logic [1:0] SRC_PORT2     = 2'h2;

  // one register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } sbd_req_t;

  // one drop record
  typedef struct packed {
    logic [3:0] reason;
    logic [1:0] port;
  } sbd_drop_t;

  // double buffered drop status
  typedef struct packed {
    sbd_drop_t b;
    logic      pend_b;
    sbd_drop_t a;
    logic      valid_a;
  } sbd_stat_t;
endpackage : sbd_pkg

// file: hdl/sbd_bank.sv
// buffer manager drop status and default tag register bank
`timescale 1ns/100ps
module sbd_bank (
  // clock and reset
  input  wire logic               I_REF_CLK,
  input  wire logic               I_RSTN,
  // system register path
  input  wire sbd_pkg::sbd_req_t  I_REG_REQ,
  output logic [31:0]             O_REG_RDATA,
  output logic                    O_REG_RACK,
  // events from the buffer manager datapath
  input  wire logic [2:0]         I_RATE_DROP,
  input  wire logic               I_DROP_EVT,
  input  wire sbd_pkg::sbd_drop_t I_DROP_INFO,
  // to egress tagging and system interrupts
  output logic [2:0]              O_DEF_PRIO,
  output logic [11:0]             O_DEF_VID,
  output logic                    O_IRQ
);

  // saturating increment shared by all counters
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v >= sbd_pkg::CNT_MAX) ? sbd_pkg::CNT_MAX : v + 32'h1;
  endfunction : sat_inc

  logic [31:0]        cnt_ff [3];
  logic [31:0]        nxt_cnt [3];
  logic [2:0]         prio_ff;
  logic [11:0]        vid_ff;
  logic               mask_ff;
  sbd_pkg::sbd_stat_t stat_ff;
  sbd_pkg::sbd_stat_t nxt_stat;
  sbd_pkg::sbd_stat_t base_stat;
  logic [31:0]        rdata_ff;
  logic [31:0]        nxt_rdata;
  logic               rack_ff;
  logic               irq_ff;
  logic               rd_pend;
  logic [2:0]         rd_cnt;

  // read strobes that carry a clear side effect
  assign rd_pend   = I_REG_REQ.rd && (I_REG_REQ.addr == sbd_pkg::ADDR_PEND);
  assign rd_cnt[0] = I_REG_REQ.rd && (I_REG_REQ.addr == sbd_pkg::ADDR_CNT0);
  assign rd_cnt[1] = I_REG_REQ.rd && (I_REG_REQ.addr == sbd_pkg::ADDR_CNT1);
  assign rd_cnt[2] = I_REG_REQ.rd && (I_REG_REQ.addr == sbd_pkg::ADDR_CNT2);

  // default tag register, plain read/write
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      prio_ff <= sbd_pkg::PRIO_RST;
      vid_ff  <= sbd_pkg::VID_RST;
    end else if (I_REG_REQ.wr && I_REG_REQ.addr == sbd_pkg::ADDR_TAG2) begin
      prio_ff <= I_REG_REQ.wdata[sbd_pkg::PRIO_LSB +: 3];
      vid_ff  <= I_REG_REQ.wdata[sbd_pkg::VID_LSB +: 12];
    end
  end

  // counter next values; a drop in the read cycle survives the clear
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      nxt_cnt[i] = rd_cnt[i] ? sbd_pkg::CNT_RST : cnt_ff[i];
      if (I_RATE_DROP[i]) begin
        nxt_cnt[i] = sat_inc(nxt_cnt[i]);
      end
    end
  end

  // per-port rate drop counters
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      for (int i = 0; i < 3; i++) begin
        cnt_ff[i] <= sbd_pkg::CNT_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mask_ff <= sbd_pkg::MASK_RST;
    end else if (I_REG_REQ.wr && I_REG_REQ.addr == sbd_pkg::ADDR_MASK) begin
      mask_ff <= I_REG_REQ.wdata[sbd_pkg::MASK_BIT];
    end
  end

  // drop status next value; the mask plays no part here
  always_comb begin
    base_stat = rd_pend ? '0 : stat_ff;
    nxt_stat  = base_stat;
    // fill A, then B, else lost
    if (I_DROP_EVT) begin
      if (!base_stat.valid_a) begin
        nxt_stat.valid_a = 1'b1;
        nxt_stat.a       = I_DROP_INFO;
      end else if (!base_stat.pend_b) begin
        // reason and port to set B
        nxt_stat.pend_b  = 1'b1;
        nxt_stat.b       = I_DROP_INFO;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // read mux; unmapped numbers read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (I_REG_REQ.addr)
      sbd_pkg::ADDR_TAG2: begin
        nxt_rdata[sbd_pkg::PRIO_LSB +: 3] = prio_ff;
        nxt_rdata[sbd_pkg::VID_LSB +: 12] = vid_ff;
      end
      sbd_pkg::ADDR_CNT0: nxt_rdata = cnt_ff[0];
      sbd_pkg::ADDR_CNT1: nxt_rdata = cnt_ff[1];
      sbd_pkg::ADDR_CNT2: nxt_rdata = cnt_ff[2];
      sbd_pkg::ADDR_MASK: nxt_rdata[sbd_pkg::MASK_BIT] = mask_ff;
      sbd_pkg::ADDR_PEND: nxt_rdata[13:0] = stat_ff;
      default:            nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data and acknowledge, one cycle after the request
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_ff <= 32'h0000_0000;
      rack_ff  <= 1'b0;
    end else begin
      rack_ff  <= I_REG_REQ.rd;
      if (I_REG_REQ.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // interrupt request, registered for a clean output
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (stat_ff.valid_a || stat_ff.pend_b) && !mask_ff;
    end
  end

  assign O_DEF_PRIO  = prio_ff;
  assign O_DEF_VID   = vid_ff;
  assign O_REG_RDATA = rdata_ff;
  assign O_REG_RACK  = rack_ff;
  assign O_IRQ       = irq_ff;

  // rule checks, sampled on the core clock
  sequence s_tag_wr;
    I_REG_REQ.wr && I_REG_REQ.addr == sbd_pkg::ADDR_TAG2;
  endsequence

  sequence s_set_a_busy;
    stat_ff.valid_a && !rd_pend;
  endsequence

  property p_tag_prio;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    s_tag_wr |=> O_DEF_PRIO == $past(I_REG_REQ.wdata[14:12]);
  endproperty
  a_tag_prio: assert property (p_tag_prio)
    else $error("default priority not written");

  property p_tag_vid;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    s_tag_wr |=> O_DEF_VID == $past(I_REG_REQ.wdata[11:0]);
  endproperty
  a_tag_vid: assert property (p_tag_vid)
    else $error("default vlan id not written");

  property p_cnt_inc;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_RATE_DROP[0] && !rd_cnt[0] && cnt_ff[0] < sbd_pkg::CNT_MAX
      |=> cnt_ff[0] == $past(cnt_ff[0]) + 32'h1;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc)
    else $error("port0 drop counter did not count");

  property p_cnt_clr;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    rd_cnt[1] && !I_RATE_DROP[1]
      |=> cnt_ff[1] == 32'h0 && O_REG_RACK && O_REG_RDATA == $past(cnt_ff[1]);
  endproperty
  a_cnt_clr: assert property (p_cnt_clr)
    else $error("port1 drop counter read did not clear");

  property p_cnt_sat;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    cnt_ff[2] == sbd_pkg::CNT_MAX && !rd_cnt[2]
      |=> cnt_ff[2] == sbd_pkg::CNT_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat)
    else $error("port2 drop counter wrapped");

  property p_mask_irq;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    mask_ff |=> !O_IRQ;
  endproperty
  a_mask_irq: assert property (p_mask_irq)
    else $error("interrupt raised while masked");

  property p_rec_masked;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_DROP_EVT && mask_ff && !stat_ff.valid_a
      |=> stat_ff.valid_a && stat_ff.a == $past(I_DROP_INFO);
  endproperty
  a_rec_masked: assert property (p_rec_masked)
    else $error("drop not recorded while masked");

  property p_fill_b;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    s_set_a_busy ##0 (I_DROP_EVT && !stat_ff.pend_b)
      |=> stat_ff.pend_b && stat_ff.b == $past(I_DROP_INFO);
  endproperty
  a_fill_b: assert property (p_fill_b)
    else $error("second drop not placed in set B");

  property p_full_hold;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    s_set_a_busy ##0 stat_ff.pend_b |=> $stable(stat_ff);
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("full status changed without read");

  property p_pend_clr;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    rd_pend && !I_DROP_EVT
      |=> !stat_ff.pend_b && !stat_ff.valid_a ##1 !O_IRQ;
  endproperty
  a_pend_clr: assert property (p_pend_clr)
    else $error("status read did not clear");

  property p_irq;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    (stat_ff.valid_a || stat_ff.pend_b) && !mask_ff |=> O_IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing");

  // tag register moves only on its own write
  property p_tag_hold;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    !(I_REG_REQ.wr && I_REG_REQ.addr == sbd_pkg::ADDR_TAG2)
      |=> $stable(O_DEF_PRIO) && $stable(O_DEF_VID);
  endproperty
  a_tag_hold: assert property (p_tag_hold)
    else $error("default tag changed without a write");

  property p_cnt_idle;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    !I_RATE_DROP[1] && !rd_cnt[1] |=> $stable(cnt_ff[1]);
  endproperty
  a_cnt_idle: assert property (p_cnt_idle)
    else $error("port1 drop counter moved without a drop");

  property p_cnt_set_wins;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    rd_cnt[2] && I_RATE_DROP[2]
      |=> cnt_ff[2] == 32'h1 && O_REG_RDATA == $past(cnt_ff[2]);
  endproperty
  a_cnt_set_wins: assert property (p_cnt_set_wins)
    else $error("drop in the clearing read cycle was lost");

  property p_cnt_bound;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    cnt_ff[0] <= sbd_pkg::CNT_MAX;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("port0 drop counter above its limit");

  property p_rack;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    1'b1 |=> O_REG_RACK == $past(I_REG_REQ.rd);
  endproperty
  a_rack: assert property (p_rack)
    else $error("read acknowledge not one cycle after the read");

  property p_mask_wr;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_REG_REQ.wr && I_REG_REQ.addr == sbd_pkg::ADDR_MASK
      |=> mask_ff == $past(I_REG_REQ.wdata[sbd_pkg::MASK_BIT]);
  endproperty
  a_mask_wr: assert property (p_mask_wr)
    else $error("mask bit not written");

  property p_b_needs_a;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    stat_ff.pend_b |-> stat_ff.valid_a;
  endproperty
  a_b_needs_a: assert property (p_b_needs_a)
    else $error("set B pending while set A is empty");

  property p_pend_rdata;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    rd_pend |=> O_REG_RDATA == {18'h0, $past(stat_ff)};
  endproperty
  a_pend_rdata: assert property (p_pend_rdata)
    else $error("status read returned a wrong word");

  sequence s_pend_clear_and_drop;
    rd_pend && I_DROP_EVT;
  endsequence

  property p_pend_set_wins;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    s_pend_clear_and_drop
      |=> stat_ff.valid_a && !stat_ff.pend_b
          && stat_ff.a == $past(I_DROP_INFO);
  endproperty
  a_pend_set_wins: assert property (p_pend_set_wins)
    else $error("drop in the status read cycle not kept in set A");

  property p_irq_low;
    @(posedge I_REF_CLK) disable iff (!I_RSTN)
    !stat_ff.valid_a && !stat_ff.pend_b |=> !O_IRQ;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt raised with no record held");

endmodule : sbd_bank

// file: tb/sbd_bank_tb_top.sv
// self-checking bench for the buffer drop status register bank
`timescale 1ns/100ps
module sbd_bank_tb_top;
  logic               I_REF_CLK;
  logic               I_RSTN;
  sbd_pkg::sbd_req_t  I_REG_REQ;
  logic [31:0]        O_REG_RDATA;
  logic               O_REG_RACK;
  logic [2:0]         I_RATE_DROP;
  logic               I_DROP_EVT;
  sbd_pkg::sbd_drop_t I_DROP_INFO;
  logic [2:0]         O_DEF_PRIO;
  logic [11:0]        O_DEF_VID;
  logic               O_IRQ;
  int                 err_total;
  int                 n_tests;
  logic [31:0]        rd_val;
  logic [31:0]        wv;
  logic [31:0]        exp_cnt [3];
  sbd_pkg::sbd_drop_t da;
  sbd_pkg::sbd_drop_t db;
  logic [3:0]         codes [9];

  sbd_bank dut (
    .I_REF_CLK   (I_REF_CLK),
    .I_RSTN      (I_RSTN),
    .I_REG_REQ   (I_REG_REQ),
    .O_REG_RDATA (O_REG_RDATA),
    .O_REG_RACK  (O_REG_RACK),
    .I_RATE_DROP (I_RATE_DROP),
    .I_DROP_EVT  (I_DROP_EVT),
    .I_DROP_INFO (I_DROP_INFO),
    .O_DEF_PRIO  (O_DEF_PRIO),
    .O_DEF_VID   (O_DEF_VID),
    .O_IRQ       (O_IRQ)
  );

  // 100 mhz clock
  initial I_REF_CLK = 1'b0;
  always #5 I_REF_CLK = ~I_REF_CLK;

  // compare and count, report at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic wrap_up;
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // read: entered at a falling edge, ack expected one cycle later
  task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
    I_REG_REQ.rd   = 1'b1;
    I_REG_REQ.addr = a;
    @(negedge I_REF_CLK);
    I_REG_REQ.rd = 1'b0;
    chk({31'h0, O_REG_RACK}, 32'h1);
    d = O_REG_RDATA;
    // a quiet edge keeps back to back strobes apart; ack gone by then
    @(negedge I_REF_CLK);
    chk({31'h0, O_REG_RACK}, 32'h0);
  endtask : reg_rd

  // write: takes effect at the next rising edge
  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    I_REG_REQ.wr    = 1'b1;
    I_REG_REQ.addr  = a;
    I_REG_REQ.wdata = d;
    @(negedge I_REF_CLK);
    I_REG_REQ.wr = 1'b0;
  endtask : reg_wr

  // one drop status event pulse
  task automatic drop_evt(input sbd_pkg::sbd_drop_t info);
    I_DROP_EVT  = 1'b1;
    I_DROP_INFO = info;
    @(negedge I_REF_CLK);
    I_DROP_EVT  = 1'b0;
    I_DROP_INFO = ~info;
    @(negedge I_REF_CLK);
  endtask : drop_evt

  // expected pending word from two record sets
  function automatic logic [31:0] pend_word(input logic va,
      input sbd_pkg::sbd_drop_t a, input logic vb,
      input sbd_pkg::sbd_drop_t b);
    pend_word = 32'h0;
    if (va) pend_word[6:0] = {a.reason, a.port, 1'b1};
    if (vb) pend_word[13:7] = {b.reason, b.port, 1'b1};
  endfunction : pend_word

  // watchdog, well beyond the expected few hundred cycles
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end

  // main sequence
  initial begin
    err_total = 0;
    n_tests = 0;
    I_RSTN = 1'b0;
    I_REG_REQ = '0;
    I_RATE_DROP = 3'h0;
    I_DROP_EVT = 1'b0;
    I_DROP_INFO = '0;
    codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hf};
    void'($urandom(32'h789a1d76));
    repeat (16) @(negedge I_REF_CLK);
    I_RSTN = 1'b1;
    @(negedge I_REF_CLK);
    // reset values of the tag, mask and pending registers
    chk({29'h0, O_DEF_PRIO}, 32'h0);
    chk({20'h0, O_DEF_VID}, 32'h1);
    reg_rd(sbd_pkg::ADDR_TAG2, rd_val);
    chk(rd_val, 32'h0000_0001);
    reg_rd(sbd_pkg::ADDR_MASK, rd_val);
    chk(rd_val, 32'h0000_0001);
    reg_rd(sbd_pkg::ADDR_PEND, rd_val);
    chk(rd_val, 32'h0);
    reg_rd(16'h1c19, rd_val);
    chk(rd_val, 32'h0);
    // default tag writes, all ones first for reserved bits
    for (int i = 0; i < 5; i++) begin
      wv = (i == 0) ? 32'hffff_ffff : $urandom;
      reg_wr(sbd_pkg::ADDR_TAG2, wv);
      chk({29'h0, O_DEF_PRIO}, {29'h0, wv[14:12]});
      chk({20'h0, O_DEF_VID}, {20'h0, wv[11:0]});
      reg_rd(sbd_pkg::ADDR_TAG2, rd_val);
      chk(rd_val, {17'h0, wv[14:0]});
    end
    // random rate drops on all ports, counters are write protected
    for (int p = 0; p < 3; p++) exp_cnt[p] = 32'h0;
    for (int i = 0; i < 60; i++) begin
      I_RATE_DROP = 3'($urandom);
      for (int p = 0; p < 3; p++) exp_cnt[p] += {31'h0, I_RATE_DROP[p]};
      @(negedge I_REF_CLK);
    end
    I_RATE_DROP = 3'h0;
    reg_wr(sbd_pkg::ADDR_CNT1, $urandom);
    for (int p = 0; p < 3; p++) begin
      reg_rd(sbd_pkg::ADDR_CNT0 + 16'(p), rd_val);
      chk(rd_val, exp_cnt[p]);
      reg_rd(sbd_pkg::ADDR_CNT0 + 16'(p), rd_val);
      chk(rd_val, 32'h0);
    end
    // drop in the same cycle as the clearing read survives
    I_RATE_DROP = 3'h4;
    repeat (2) @(negedge I_REF_CLK);
    reg_rd(sbd_pkg::ADDR_CNT2, rd_val);
    I_RATE_DROP = 3'h0;
    chk(rd_val, 32'h2);
    // the read edge and the quiet edge after it both count
    reg_rd(sbd_pkg::ADDR_CNT2, rd_val);
    chk(rd_val, 32'h2);
    // every reason code through set a then set b, third drop lost
    reg_wr(sbd_pkg::ADDR_MASK, 32'h0);
    for (int i = 0; i < 9; i++) begin
      da.reason = codes[i];
      da.port = 2'($urandom_range(2));
      db.reason = codes[(i + 1) % 9];
      db.port = 2'($urandom_range(2));
      drop_evt(da);
      chk({31'h0, O_IRQ}, 32'h1);
      drop_evt(db);
      chk({31'h0, O_IRQ}, 32'h1);
      drop_evt(~da);
      reg_rd(sbd_pkg::ADDR_PEND, rd_val);
      chk(rd_val, pend_word(1'b1, da, 1'b1, db));
      @(negedge I_REF_CLK);
      chk({31'h0, O_IRQ}, 32'h0);
      reg_rd(sbd_pkg::ADDR_PEND, rd_val);
      chk(rd_val, 32'h0);
    end
    // masked drop still recorded, irq only after unmask
    reg_wr(sbd_pkg::ADDR_MASK, 32'hffff_ffff);
    reg_rd(sbd_pkg::ADDR_MASK, rd_val);
    chk(rd_val, 32'h1);
    drop_evt(db);
    repeat (3) @(negedge I_REF_CLK);
    chk({31'h0, O_IRQ}, 32'h0);
    reg_wr(sbd_pkg::ADDR_MASK, 32'h0);
    @(negedge I_REF_CLK);
    chk({31'h0, O_IRQ}, 32'h1);
    reg_rd(sbd_pkg::ADDR_PEND, rd_val);
    chk(rd_val, pend_word(1'b1, db, 1'b0, da));
    // drop in the clearing read cycle lands in set A, the next in B
    I_DROP_EVT  = 1'b1;
    I_DROP_INFO = da;
    reg_rd(sbd_pkg::ADDR_PEND, rd_val);
    I_DROP_EVT  = 1'b0;
    chk(rd_val, 32'h0);
    reg_rd(sbd_pkg::ADDR_PEND, rd_val);
    chk(rd_val, pend_word(1'b1, da, 1'b1, da));
    // reset in mid-run restores the tag, mask and pending registers
    drop_evt(db);
    I_RSTN = 1'b0;
    @(negedge I_REF_CLK);
    I_RSTN = 1'b1;
    @(negedge I_REF_CLK);
    chk({29'h0, O_DEF_PRIO}, 32'h0);
    chk({20'h0, O_DEF_VID}, 32'h1);
    reg_rd(sbd_pkg::ADDR_MASK, rd_val);
    chk(rd_val, 32'h1);
    reg_rd(sbd_pkg::ADDR_PEND, rd_val);
    chk(rd_val, 32'h0);
    wrap_up();
  end
endmodule : sbd_bank_tb_top
